/* File: serial_port_pkg.sv */
package serial_port_pkg;

   // Byte addresses of the register words
   localparam logic [4:0] ADDR_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_DATA    = 5'h04;
   localparam logic [4:0] ADDR_TIMER   = 5'h08;
   localparam logic [4:0] ADDR_RELOAD  = 5'h0C;
   localparam logic [4:0] ADDR_COUNT   = 5'h10;
   localparam logic [4:0] ADDR_STATUS  = 5'h14;
   localparam logic [4:0] ADDR_ENABLE  = 5'h18;
   localparam logic [4:0] ADDR_CLEAR   = 5'h1C;

   // Field positions in the serial control register
   localparam int CTL_FRAME_WIDTH = 7;
   localparam int CTL_STOP_CHECK  = 5;
   localparam int CTL_RX_ENABLE   = 4;
   localparam int CTL_NINTH_BIT   = 2;
   localparam int CTL_TX_DONE     = 1;
   localparam int CTL_RX_DONE     = 0;

   // Field positions in the timer control register
   localparam int TMR_RUN     = 0;
   localparam int TMR_SRC_LSB = 1;

   // Field positions in status, enable and clear
   localparam int EVT_RX_DONE = 0;
   localparam int EVT_TX_DONE = 1;

   // Reset values
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [7:0] RESET_RELOAD = 8'h00;

   // Baud timer clock sources
   localparam logic [2:0] SRC_SYS    = 3'h0;
   localparam logic [2:0] SRC_DIV4   = 3'h1;
   localparam logic [2:0] SRC_DIV12  = 3'h2;
   localparam logic [2:0] SRC_DIV48  = 3'h3;
   localparam logic [2:0] SRC_EXT8   = 3'h4;

   // Prescaler terminal counts (divide minus one)
   localparam logic [5:0] PRE_LAST_DIV4  = 6'h03;
   localparam logic [5:0] PRE_LAST_DIV12 = 6'h0B;
   localparam logic [5:0] PRE_LAST_DIV48 = 6'h2F;
   localparam logic [2:0] EXT_LAST_DIV8  = 3'h7;

   // Counter top value before overflow
   localparam logic [7:0] TIMER_TOP = 8'hFF;

   // Frame layout: start, eight data bits, stop
   localparam logic [3:0] DATA_BITS   = 4'h8;
   localparam logic [3:0] FRAME_LAST  = 4'h9;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avl_req_t;

   typedef struct packed {
      logic [7:0] count;
      logic       half;
   } baud_state_t;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_BUSY = 2'b10
   } tx_state_t;

endpackage

/* File: baud_timer.sv */
`timescale 1ns/10ps
// Eight-bit auto-reload counter with a halving stage on its overflow stream
module baud_timer
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       run,
   input  wire logic       force_reload,
   input  wire logic [7:0] reload_value,
   output logic [7:0]      count,
   output logic            baud_pulse
);

   serial_port_pkg::baud_state_t s_q;
   serial_port_pkg::baud_state_t s_d;
   logic                         ovf;

   // Overflow after TIMER_TOP, so the period is 256 minus the reload byte
   assign ovf        = run & tick & (s_q.count == serial_port_pkg::TIMER_TOP);
   // Every second overflow makes one baud pulse; the first after a forced reload counts
   assign baud_pulse = ovf & ~s_q.half;
   assign count      = s_q.count;

   // Reload on overflow or on demand; a forced reload also restarts the halving phase
   always_comb
   begin
      s_d = s_q;
      if (force_reload)
      begin
         s_d.count = reload_value;
         s_d.half  = 1'b0;
      end
      else if (ovf)
      begin
         s_d.count = reload_value;
         s_d.half  = ~s_q.half;
      end
      else if (run & tick)
      begin
         s_d.count = s_q.count + 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '{count: serial_port_pkg::RESET_BYTE, half: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule

/* File: serial_port.sv */
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
// Operation
// - Transmit and receive clocks from reload counters
// - Each overflow stream halved into baud rate
// - Receive copy runs with timer, same reload
// - Start edge forces receive counter reload
// - Baud equals clock over 256-reload, halved
// - Timer clock: sys, /4, /12, /48, ext/8
// - External oscillator may clock the timer
// - Full duplex; frame width bit stored, no effect
// - Ten-bit frame, start, LSB first, stop
// - Receive byte to buffer, stop to flag
// - Writing data buffer starts transmission
// - Transmit done set at stop-bit start
// - Receiver only accepts when enabled
// - Load only if done clear, stop high if checked
// - Else buffer, stop flag, done unchanged
// - Overrun keeps first byte, drops later
// - Interrupt when enabled done flag sets
module serial_port
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire serial_port_pkg::avl_req_t avl_req,
   output logic [31:0]                    avl_readdata,
   output logic                           avl_waitrequest,
   input  wire logic                      rxd,
   output logic                           txd,
   input  wire logic                      ext_osc_clk,
   output logic                           irq
);

   typedef struct packed {
      logic [31:0]                  readdata;
      logic                         waitreq;
      logic                         irq;
      logic                         txd;
      logic                         frame_width;
      logic                         stop_check;
      logic                         rx_enable;
      logic                         ninth_bit;
      logic [1:0]                   status;
      logic [1:0]                   enable;
      logic                         timer_run;
      logic [2:0]                   timer_src;
      logic [7:0]                   reload;
      logic [7:0]                   rx_buffer;
      logic [5:0]                   pre;
      logic [2:0]                   ext_cnt;
      logic                         ext_prev;
      logic                         rxd_prev;
      serial_port_pkg::tx_state_t   tx_state;
      logic [9:0]                   tx_shift;
      logic [3:0]                   tx_bits;
      logic                         tx_pending;
      serial_port_pkg::rx_state_t   rx_state;
      logic [7:0]                   rx_shift;
      logic [3:0]                   rx_bits;
   } state_t;

   state_t     s_q;
   state_t     s_d;
   logic       req;
   logic       take;
   logic       wr_lo;
   logic       tick;
   logic       ext_edge;
   logic       start_edge;
   logic       tx_pulse;
   logic       rx_pulse;
   logic [7:0] tx_count;
   logic [7:0] ctl_read;
   logic [1:0] set_evt;
   logic       tx_data_done;
   logic       tx_frame_done;
   logic       rx_data_done;
   logic       pre_hold;

   // A request is taken on the edge where waitrequest is still high
   assign req   = avl_req.read | avl_req.write;
   assign take  = req & s_q.waitreq;
   assign wr_lo = take & avl_req.write & avl_req.byteenable[0];

   // Frame position decodes; the stop bit follows the eighth data bit
   assign tx_data_done  = (s_q.tx_bits == serial_port_pkg::DATA_BITS);
   assign tx_frame_done = (s_q.tx_bits == serial_port_pkg::FRAME_LAST);
   assign rx_data_done  = (s_q.rx_bits == serial_port_pkg::DATA_BITS - 4'h1);

   // External oscillator sampled here; edges counted down by eight
   assign ext_edge = ext_osc_clk & ~s_q.ext_prev;

   // Prescaler rests at zero while bypassed, so a later divide starts on a full period
   assign pre_hold = (s_q.timer_src == serial_port_pkg::SRC_SYS) | (s_q.timer_src == serial_port_pkg::SRC_EXT8);

   // Timer clock source mux; prescaler wraps at the chosen terminal count
   always_comb
   begin
      case (s_q.timer_src)
         serial_port_pkg::SRC_SYS:   tick = 1'b1;
         serial_port_pkg::SRC_DIV4:  tick = (s_q.pre == serial_port_pkg::PRE_LAST_DIV4);
         serial_port_pkg::SRC_DIV12: tick = (s_q.pre == serial_port_pkg::PRE_LAST_DIV12);
         serial_port_pkg::SRC_DIV48: tick = (s_q.pre == serial_port_pkg::PRE_LAST_DIV48);
         serial_port_pkg::SRC_EXT8:  tick = ext_edge & (s_q.ext_cnt == serial_port_pkg::EXT_LAST_DIV8);
         default:                    tick = 1'b0;
      endcase
   end

   // Falling edge on the receive pin while idle and enabled
   assign start_edge = (s_q.rx_state == serial_port_pkg::RX_IDLE) & s_q.rx_enable & s_q.timer_run
                       & s_q.rxd_prev & ~rxd;

   // Transmit counter is the software-visible low count
   baud_timer u_tx_timer
   (
      .clk          (clk),
      .rst          (rst),
      .tick         (tick),
      .run          (s_q.timer_run),
      .force_reload (1'b0),
      .reload_value (s_q.reload),
      .count        (tx_count),
      .baud_pulse   (tx_pulse)
   );

   // Hidden receive copy; same run and reload, realigned at each start
   baud_timer u_rx_timer
   (
      .clk          (clk),
      .rst          (rst),
      .tick         (tick),
      .run          (s_q.timer_run),
      .force_reload (start_edge),
      .reload_value (s_q.reload),
      .count        (),
      .baud_pulse   (rx_pulse)
   );

   // Control register as software sees it
   always_comb
   begin
      ctl_read                                  = 8'h00;
      ctl_read[serial_port_pkg::CTL_FRAME_WIDTH] = s_q.frame_width;
      ctl_read[serial_port_pkg::CTL_STOP_CHECK]  = s_q.stop_check;
      ctl_read[serial_port_pkg::CTL_RX_ENABLE]   = s_q.rx_enable;
      ctl_read[serial_port_pkg::CTL_NINTH_BIT]   = s_q.ninth_bit;
      ctl_read[serial_port_pkg::CTL_TX_DONE]     = s_q.status[serial_port_pkg::EVT_TX_DONE];
      ctl_read[serial_port_pkg::CTL_RX_DONE]     = s_q.status[serial_port_pkg::EVT_RX_DONE];
   end

   // Next state of the whole port
   always_comb
   begin
      s_d     = s_q;
      set_evt = 2'h0;

      // Bus handshake: one wait cycle, then a single cycle with waitrequest low
      s_d.waitreq = ~take;
      if (take & avl_req.read)
      begin
         case (avl_req.address)
            serial_port_pkg::ADDR_CONTROL: s_d.readdata = {24'h00_0000, ctl_read};
            serial_port_pkg::ADDR_DATA:    s_d.readdata = {24'h00_0000, s_q.rx_buffer};
            serial_port_pkg::ADDR_TIMER:   s_d.readdata = {28'h000_0000, s_q.timer_src, s_q.timer_run};
            serial_port_pkg::ADDR_RELOAD:  s_d.readdata = {24'h00_0000, s_q.reload};
            serial_port_pkg::ADDR_COUNT:   s_d.readdata = {24'h00_0000, tx_count};
            serial_port_pkg::ADDR_STATUS:  s_d.readdata = {24'h00_0000, 6'h00, s_q.status};
            serial_port_pkg::ADDR_ENABLE:  s_d.readdata = {24'h00_0000, 6'h00, s_q.enable};
            default:                       s_d.readdata = 32'h0000_0000;
         endcase
      end

      // Register writes; only the low byte lane carries data
      if (wr_lo)
      begin
         case (avl_req.address)
            serial_port_pkg::ADDR_CONTROL:
            begin
               s_d.frame_width = avl_req.writedata[serial_port_pkg::CTL_FRAME_WIDTH];
               s_d.stop_check  = avl_req.writedata[serial_port_pkg::CTL_STOP_CHECK];
               s_d.rx_enable   = avl_req.writedata[serial_port_pkg::CTL_RX_ENABLE];
            end
            serial_port_pkg::ADDR_DATA:
            begin
               // A byte written while another is queued or on the line is dropped
               if ((s_q.tx_state == serial_port_pkg::TX_IDLE) & ~s_q.tx_pending)
               begin
                  s_d.tx_pending = 1'b1;
                  s_d.tx_shift   = {1'b1, avl_req.writedata[7:0], 1'b0};
               end
            end
            serial_port_pkg::ADDR_TIMER:
            begin
               s_d.timer_run = avl_req.writedata[serial_port_pkg::TMR_RUN];
               s_d.timer_src = avl_req.writedata[serial_port_pkg::TMR_SRC_LSB +: 3];
            end
            serial_port_pkg::ADDR_RELOAD: s_d.reload = avl_req.writedata[7:0];
            serial_port_pkg::ADDR_ENABLE: s_d.enable = avl_req.writedata[1:0];
            serial_port_pkg::ADDR_CLEAR:  s_d.status = s_q.status & ~avl_req.writedata[1:0];
            default:                      s_d.status = s_q.status;
         endcase
      end

      // Prescaler runs unless bypassed; external edge divider runs freely
      s_d.ext_prev = ext_osc_clk;
      s_d.rxd_prev = rxd;
      if (ext_edge)
      begin
         s_d.ext_cnt = s_q.ext_cnt + 3'h1;
      end
      if (tick | pre_hold)
      begin
         s_d.pre = 6'h00;
      end
      else
      begin
         s_d.pre = s_q.pre + 6'h01;
      end

      // Transmitter: start waits for the next transmit baud pulse
      case (s_q.tx_state)
         serial_port_pkg::TX_IDLE:
         begin
            // Start bit leaves first; the shifter refills with idle ones
            if (s_q.tx_pending & tx_pulse)
            begin
               s_d.tx_state   = serial_port_pkg::TX_BUSY;
               s_d.tx_pending = 1'b0;
               s_d.txd        = s_q.tx_shift[0];
               s_d.tx_shift   = {1'b1, s_q.tx_shift[9:1]};
               s_d.tx_bits    = 4'h0;
            end
         end
         serial_port_pkg::TX_BUSY:
         begin
            if (tx_pulse)
            begin
               if (tx_frame_done)
               begin
                  s_d.tx_state = serial_port_pkg::TX_IDLE;
                  s_d.txd      = 1'b1;
               end
               else
               begin
                  s_d.txd      = s_q.tx_shift[0];
                  s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]};
                  s_d.tx_bits  = s_q.tx_bits + 4'h1;
                  // Stop bit now going out, data is done
                  set_evt[serial_port_pkg::EVT_TX_DONE] = tx_data_done;
               end
            end
         end
         default:
         begin
            // An illegal state falls back to idle with the line high
            s_d.tx_state = serial_port_pkg::TX_IDLE;
            s_d.txd      = 1'b1;
         end
      endcase

      // Receiver samples mid-bit on the odd overflows of its own counter
      case (s_q.rx_state)
         serial_port_pkg::RX_IDLE:
         begin
            if (start_edge)
            begin
               s_d.rx_state = serial_port_pkg::RX_START;
            end
         end
         serial_port_pkg::RX_START:
         begin
            if (rx_pulse)
            begin
               // A glitch shorter than half a bit is not a start
               s_d.rx_state = rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
               s_d.rx_bits  = 4'h0;
            end
         end
         serial_port_pkg::RX_DATA:
         begin
            if (rx_pulse)
            begin
               // Least significant bit arrives first and ends at the bottom
               s_d.rx_shift = {rxd, s_q.rx_shift[7:1]};
               s_d.rx_bits  = s_q.rx_bits + 4'h1;
               if (rx_data_done)
               begin
                  s_d.rx_state = serial_port_pkg::RX_STOP;
               end
            end
         end
         serial_port_pkg::RX_STOP:
         begin
            if (rx_pulse)
            begin
               s_d.rx_state = serial_port_pkg::RX_IDLE;
               // Overrun leaves the held byte alone; the new one is dropped
               if (~s_q.status[serial_port_pkg::EVT_RX_DONE] & (~s_q.stop_check | rxd))
               begin
                  s_d.rx_buffer                         = s_q.rx_shift;
                  s_d.ninth_bit                         = rxd;
                  set_evt[serial_port_pkg::EVT_RX_DONE] = 1'b1;
               end
            end
         end
         default: s_d.rx_state = serial_port_pkg::RX_IDLE;
      endcase

      // Hardware sets win over a clear in the same cycle
      s_d.status = s_d.status | set_evt;
      s_d.irq    = |(s_d.status & s_q.enable);
   end

   // Synchronous reset; the line idles high and the bus shows no answer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q             <= '0;
         s_q.waitreq     <= 1'b1;
         s_q.txd         <= 1'b1;
         s_q.ext_prev    <= 1'b0;
         s_q.rxd_prev    <= 1'b1;
         s_q.reload      <= serial_port_pkg::RESET_RELOAD;
         s_q.rx_buffer   <= serial_port_pkg::RESET_BYTE;
         s_q.tx_shift    <= 10'h3FF;
         s_q.tx_state    <= serial_port_pkg::TX_IDLE;
         s_q.rx_state    <= serial_port_pkg::RX_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign avl_readdata    = s_q.readdata;
   assign avl_waitrequest = s_q.waitreq;
   assign txd             = s_q.txd;
   assign irq             = s_q.irq;

endmodule

/* File: serial_port_checker.sv */
`timescale 1ns/10ps
// Port-level checks on the register handshake, the reset state, the interrupt and the line
module serial_port_checker
(
   input wire logic                      clk,
   input wire logic                      rst,
   input wire serial_port_pkg::avl_req_t avl_req,
   input wire logic [31:0]               avl_readdata,
   input wire logic                      avl_waitrequest,
   input wire logic                      rxd,
   input wire logic                      txd,
   input wire logic                      ext_osc_clk,
   input wire logic                      irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // A request is taken only while waitrequest stands high
   sequence req_taken;
      (avl_req.read || avl_req.write) && avl_waitrequest;
   endsequence
   // Exactly one low cycle, then idle again
   sequence one_cycle_answer;
      !avl_waitrequest ##1 avl_waitrequest;
   endsequence

   chk_bus_answer: assert property (req_taken |=> one_cycle_answer)
      else $error("bus answer not exactly one cycle after request");
   chk_wait_cause: assert property ($fell(avl_waitrequest) |-> $past(avl_req.read || avl_req.write))
      else $error("waitrequest dropped without a request");
   chk_upper_zero: assert property (avl_readdata[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   chk_read_hold: assert property (!$past(rst) && !$past(avl_req.read && avl_waitrequest) |-> $stable(avl_readdata))
      else $error("read data changed without a read");
   chk_reset_state: assert property (disable iff (1'b0) rst |=> avl_waitrequest && txd && !irq)
      else $error("outputs not idle after reset");
   chk_reset_data: assert property ($fell(rst) |-> avl_readdata == 32'h0000_0000)
      else $error("read data not cleared by reset");
   chk_irq_clear: assert property ($fell(irq) |-> $past(avl_req.write, 1) || $past(avl_req.write, 2))
      else $error("interrupt dropped without a register write");
   // Halving the overflow stream makes every bit at least two clocks long
   chk_bit_halving: assert property ($changed(txd) |=> $stable(txd))
      else $error("transmit bit shorter than two clocks");
endmodule

/* File: serial_link_model.sv */
`timescale 1ns/10ps
// Remote transceiver; bit length in clocks is set by the bench to match the port's rate
module serial_link_model
(
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   int         bit_clks = 16;
   int         n_got = 0;
   logic [7:0] got_byte;
   logic       got_stop;

   initial rxd = 1'b1;

   // Start low, eight bits LSB first, stop; idle line is high
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         rxd <= f[i];
         repeat (bit_clks - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask

   // Sample each data bit at its middle, stop bit included
   initial
   begin
      forever
      begin
         @(negedge txd);
         repeat (bit_clks / 2) @(posedge clk);
         for (int i = 0; i < 9; i++)
         begin
            repeat (bit_clks) @(posedge clk);
            if (i < 8)
               got_byte[i] = txd;
            else
               got_stop = txd;
         end
         n_got++;
      end
   end
endmodule

/* File: async_serial_port_with_baud_timer_test.sv */
`timescale 1ns/10ps
module async_serial_port_with_baud_timer_test;
   logic                      clk = 1'b0;
   logic                      rst = 1'b1;
   serial_port_pkg::avl_req_t avl_req = '0;
   logic [31:0]               avl_readdata;
   logic                      avl_waitrequest;
   logic                      rxd;
   logic                      txd;
   logic                      ext_osc_clk = 1'b0;
   logic                      irq;
   int                        n_mismatch = 0;
   int                        samples_checked = 0;
   logic [31:0]               rd;
   logic [2:0]                src [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
   logic [7:0]                rl [4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
   int                        bits [4] = '{16, 24, 96, 64};

   // 25 MHz system clock
   always #20 clk = ~clk;
   // External oscillator at a quarter of the system rate, free running
   always #80 ext_osc_clk = ~ext_osc_clk;

   serial_port dut (.clk(clk), .rst(rst), .avl_req(avl_req), .avl_readdata(avl_readdata),
      .avl_waitrequest(avl_waitrequest), .rxd(rxd), .txd(txd), .ext_osc_clk(ext_osc_clk), .irq(irq));
   serial_link_model link (.clk(clk), .txd(txd), .rxd(rxd));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // One Avalon access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      avl_req <= '{read: !wr, write: wr, address: a, writedata: {24'h00_0000, d}, byteenable: 4'hF};
      @(posedge clk);
      while (avl_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avl_readdata;
      avl_req <= '0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rd[7:0], exp);
   endtask

   // Transmit a byte and compare what the far end saw
   task automatic tx_byte(input logic [7:0] b);
      int k;
      k = link.n_got;
      bus(1'b1, serial_port_pkg::ADDR_DATA, b);
      wait (link.n_got == k + 1);
      check(link.got_byte, b);
      check({7'h00, link.got_stop}, 8'h01);
      // Let the stop bit finish before the timer or the data register is touched again
      repeat (link.bit_clks) @(posedge clk);
   endtask

   task automatic summarize;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(serial_port_pkg::ADDR_CONTROL, 8'h00);
      rd_chk(serial_port_pkg::ADDR_STATUS, 8'h00);
      rd_chk(5'h1E, 8'h00);
      bus(1'b1, serial_port_pkg::ADDR_RELOAD, 8'hF8);
      bus(1'b1, serial_port_pkg::ADDR_TIMER, 8'h01);
      bus(1'b1, serial_port_pkg::ADDR_ENABLE, 8'h03);
      bus(1'b1, serial_port_pkg::ADDR_CONTROL, 8'h10);
      tx_byte(8'hA5);
      check({7'h00, irq}, 8'h01);
      rd_chk(serial_port_pkg::ADDR_STATUS, 8'h02);
      rd_chk(serial_port_pkg::ADDR_CONTROL, 8'h12);
      bus(1'b1, serial_port_pkg::ADDR_CLEAR, 8'h02);
      rd_chk(serial_port_pkg::ADDR_STATUS, 8'h00);
      check({7'h00, irq}, 8'h00);
      link.send(8'h3C, 1'b1);
      rd_chk(serial_port_pkg::ADDR_DATA, 8'h3C);
      rd_chk(serial_port_pkg::ADDR_CONTROL, 8'h15);
      check({7'h00, irq}, 8'h01);
      link.send(8'h55, 1'b1);
      rd_chk(serial_port_pkg::ADDR_DATA, 8'h3C);
      bus(1'b1, serial_port_pkg::ADDR_CLEAR, 8'h01);
      bus(1'b1, serial_port_pkg::ADDR_CONTROL, 8'h30);
      link.send(8'h66, 1'b0);
      rd_chk(serial_port_pkg::ADDR_STATUS, 8'h00);
      rd_chk(serial_port_pkg::ADDR_DATA, 8'h3C);
      bus(1'b1, serial_port_pkg::ADDR_CONTROL, 8'h10);
      link.send(8'h81, 1'b0);
      rd_chk(serial_port_pkg::ADDR_CONTROL, 8'h11);
      rd_chk(serial_port_pkg::ADDR_DATA, 8'h81);
      bus(1'b1, serial_port_pkg::ADDR_CLEAR, 8'h01);
      fork
         link.send(8'hC3, 1'b1);
         tx_byte(8'h96);
      join
      rd_chk(serial_port_pkg::ADDR_DATA, 8'hC3);
      bus(1'b1, serial_port_pkg::ADDR_CLEAR, 8'h03);
      bus(1'b1, serial_port_pkg::ADDR_CONTROL, 8'h00);
      link.send(8'h18, 1'b1);
      rd_chk(serial_port_pkg::ADDR_STATUS, 8'h00);
      // Each clock source but sys with a reload that gives a known bit length
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, serial_port_pkg::ADDR_RELOAD, rl[i]);
         bus(1'b1, serial_port_pkg::ADDR_TIMER, {4'h0, src[i], 1'b1});
         link.bit_clks = bits[i];
         tx_byte(8'h5A ^ 8'(i));
      end
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule

bind serial_port serial_port_checker chk_i (.clk(clk), .rst(rst), .avl_req(avl_req), .avl_readdata(avl_readdata),
   .avl_waitrequest(avl_waitrequest), .rxd(rxd), .txd(txd), .ext_osc_clk(ext_osc_clk), .irq(irq));
